/* File: include/tsl_pkg.sv */
// Package for the trigger sequencer limit registers: offsets, layouts, types
package tsl_pkg;

	// ****************************************************************
	// Register map (word aligned byte addresses)
	// ****************************************************************
	localparam int          ADDR_W          = 4;           // Byte address width
	localparam logic [3:0]  OFF_STEP_DELAY  = 4'h0;        // Step delay limit
	localparam logic [3:0]  OFF_CNT0_LIMIT  = 4'h4;        // Counter 0 limit
	localparam logic [3:0]  OFF_CNT1_LIMIT  = 4'h8;        // Counter 1 limit
	localparam logic [3:0]  OFF_CONTROL     = 4'hC;        // Enable/run flags and status

	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam int          LIM_W           = 16;          // Limit register width
	localparam logic [15:0] LIM_RESET       = 16'h0000;    // Limit reset value
	localparam int          CTL_EN_BIT      = 0;           // Sequencer enable flag
	localparam int          CTL_RUN_BIT     = 1;           // Sequencer run flag
	localparam int          CTL_LOCK_BIT    = 2;           // Read-only lock status
	localparam int          CTL_BUSY_BIT    = 3;           // Step in progress status
	localparam logic [15:0] STEP_BASE       = 16'h0001;    // Base step delay in clocks

	// Bus request bundle
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} tsl_req_t;

	// Limit values handed to the rest of the sequencer
	typedef struct packed {
		logic [LIM_W-1:0] step_delay;
		logic [LIM_W-1:0] counter0;
		logic [LIM_W-1:0] counter1;
	} tsl_limits_t;

	// Step timer states
	typedef enum logic [0:0] {ST_IDLE, ST_STEP} tsl_state_t;

endpackage

/* File: src/tsl_limit_regs.sv */
// Trigger sequencer limit registers with step timer and Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Step takes step delay limit plus one clocks
// - Delay and counter0 limits locked while enabled+running
// - Counter0 limit gives jump loop/counter0 terminal
// - Counter1 limit gives jump loop/counter1 terminal
module tsl_limit_regs (
	input  wire logic                   i_mclk,         // Sequencer clock
	input  wire logic                   i_arst_n,       // Async reset, active low
	input  wire logic                   i_ce,           // Clock enable, freezes state when low
	input  wire tsl_pkg::tsl_req_t      i_req,          // Avalon-MM request
	output logic [31:0]                 o_readdata,     // Avalon-MM read data
	output logic                        o_readdatavalid,// Read data valid pulse
	output logic                        o_waitrequest,  // Avalon-MM wait request
	input  wire logic                   i_step_start,   // Step command start pulse
	output logic                        o_step_done,    // Step complete pulse
	output tsl_pkg::tsl_limits_t        o_limits,       // Limit values to the sequencer
	output logic                        o_enable,       // Sequencer enable flag
	output logic                        o_running       // Sequencer run flag
);
	import tsl_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	tsl_limits_t      lim_q,  lim_d;        // Limit registers
	logic             en_q,   en_d;         // Enable flag
	logic             run_q,  run_d;        // Run flag
	logic             ack_q,  ack_d;        // One-cycle bus answer
	logic [31:0]      rd_q,   rd_d;         // Registered read data
	logic             rdv_q,  rdv_d;        // Read valid
	tsl_state_t       st_q,   st_d;         // Step timer state
	logic [LIM_W-1:0] cnt_q,  cnt_d;        // Step timer count
	logic             done_q, done_d;       // Step done pulse
	logic             lock;                 // Protected registers read-only
	logic             req;                  // Any access pending

	// Apply byte enables to the low half of a write
	function automatic logic [LIM_W-1:0] merge16(input logic [LIM_W-1:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = old;
		if (be[0]) merge16[7:0]  = wd[7:0];
		if (be[1]) merge16[15:8] = wd[15:8];
	endfunction

	assign lock = en_q & run_q;
	assign req  = i_req.read | i_req.write;

	// ****************************************************************
	// Register file and bus next state
	// ****************************************************************
	// Every access answers on the second cycle: first cycle waits, second
	// releases. Fixed latency keeps the slave simple at a small bus cost.
	always_comb begin
		lim_d  = lim_q;
		en_d   = en_q;
		run_d  = run_q;
		ack_d  = 1'b0;
		rd_d   = rd_q;
		rdv_d  = 1'b0;
		if (req && !ack_q) begin
			ack_d = 1'b1;
			if (i_req.write) begin
				case (i_req.address)
					// Writes are dropped while locked, not delayed
					OFF_STEP_DELAY: begin
						if (!lock) lim_d.step_delay = merge16(lim_q.step_delay,
							i_req.writedata, i_req.byteenable);
					end
					OFF_CNT0_LIMIT: begin
						if (!lock) lim_d.counter0 = merge16(lim_q.counter0,
							i_req.writedata, i_req.byteenable);
					end
					// Counter 1 limit stays writable at all times
					OFF_CNT1_LIMIT: begin
						lim_d.counter1 = merge16(lim_q.counter1,
							i_req.writedata, i_req.byteenable);
					end
					OFF_CONTROL: begin
						if (i_req.byteenable[0]) begin
							en_d  = i_req.writedata[CTL_EN_BIT];
							run_d = i_req.writedata[CTL_RUN_BIT];
						end
					end
					default: begin
						// Unmapped writes are acknowledged and discarded
					end
				endcase
			end else begin
				rdv_d = 1'b1;
				case (i_req.address)
					OFF_STEP_DELAY: rd_d = {16'h0000, lim_q.step_delay};
					OFF_CNT0_LIMIT: rd_d = {16'h0000, lim_q.counter0};
					OFF_CNT1_LIMIT: rd_d = {16'h0000, lim_q.counter1};
					OFF_CONTROL: begin
						rd_d = 32'h0000_0000;
						rd_d[CTL_EN_BIT]   = en_q;
						rd_d[CTL_RUN_BIT]  = run_q;
						rd_d[CTL_LOCK_BIT] = lock;
						rd_d[CTL_BUSY_BIT] = (st_q == ST_STEP);
					end
					default: rd_d = 32'h0000_0000;    // Unmapped reads as zero
				endcase
			end
		end
	end

	// ****************************************************************
	// Step timer next state
	// ****************************************************************
	// Step lasts step_delay+1 clocks from start to done pulse.
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		done_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (i_step_start && lock) begin
					st_d  = ST_STEP;
					cnt_d = lim_q.step_delay;
				end
			end
			ST_STEP: begin
				if (cnt_q == LIM_RESET) begin
					st_d   = ST_IDLE;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q - STEP_BASE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lim_q  <= '{LIM_RESET, LIM_RESET, LIM_RESET};
			en_q   <= 1'b0;
			run_q  <= 1'b0;
			ack_q  <= 1'b0;
			rd_q   <= 32'h0000_0000;
			rdv_q  <= 1'b0;
			st_q   <= ST_IDLE;
			cnt_q  <= LIM_RESET;
			done_q <= 1'b0;
		end else if (i_ce) begin
			lim_q  <= lim_d;
			en_q   <= en_d;
			run_q  <= run_d;
			ack_q  <= ack_d;
			rd_q   <= rd_d;
			rdv_q  <= rdv_d;
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	// Read data in the same cycle waitrequest drops
	assign o_waitrequest   = req & ~(ack_q & i_ce);
	assign o_readdata      = rd_q;
	assign o_readdatavalid = rdv_q;
	assign o_step_done     = done_q;
	assign o_limits        = lim_q;
	assign o_enable        = en_q;
	assign o_running       = run_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	locked_sd_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		lock |=> lim_q.step_delay == $past(lim_q.step_delay))
		else $error("step delay limit changed while locked");

	locked_c0_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		lock |=> lim_q.counter0 == $past(lim_q.counter0))
		else $error("counter0 limit changed while locked");

	step_len_one_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && st_q == ST_IDLE && i_step_start && lock && lim_q.step_delay == 16'h0000)
		|=> ##1 done_q)
		else $error("zero delay step did not finish in one clock");

	step_len_two_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && st_q == ST_IDLE && i_step_start && lock && lim_q.step_delay == 16'h0001)
		##1 i_ce[*2] |=> done_q)
		else $error("delay one step did not finish in two clocks");

	c1_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && i_req.write && !ack_q && i_req.address == OFF_CNT1_LIMIT
		&& i_req.byteenable[1:0] == 2'h3) |=> lim_q.counter1 == $past(i_req.writedata[15:0]))
		else $error("counter1 limit write lost");

	c0_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && !lock && i_req.write && !ack_q && i_req.address == OFF_CNT0_LIMIT
		&& i_req.byteenable[1:0] == 2'h3) |=> lim_q.counter0 == $past(i_req.writedata[15:0]))
		else $error("counter0 limit write lost while unlocked");

	limits_out_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(!i_req.write || !i_ce) |=> o_limits == $past(o_limits))
		else $error("limit changed without a write");

	bus_answer_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && req && !ack_q) ##1 i_ce |-> !o_waitrequest)
		else $error("bus access not answered on second cycle");

	// Unlocked step delay writes must land, or a later step runs stale
	sd_write_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && !lock && i_req.write && !ack_q && i_req.address == OFF_STEP_DELAY
		&& i_req.byteenable[1:0] == 2'h3)
		|=> lim_q.step_delay == $past(i_req.writedata[15:0]))
		else $error("step delay limit write lost while unlocked");

	// Low byte write to counter 1 keeps the high byte untouched
	c1_low_byte_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(i_ce && i_req.write && !ack_q && i_req.address == OFF_CNT1_LIMIT
		&& i_req.byteenable[1:0] == 2'h1)
		|=> lim_q.counter1 == {$past(lim_q.counter1[15:8]), $past(i_req.writedata[7:0])})
		else $error("counter1 limit low byte write wrong");

	// Timer stays idle unless the sequencer is enabled and running
	idle_unlocked_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
		(st_q == ST_IDLE && !lock) |=> st_q == ST_IDLE)
		else $error("step started while sequencer not running");

endmodule

`default_nettype wire

/* File: dv/tb.sv */
// Testbench for the trigger sequencer limit registers
`timescale 1ns/100ps
`default_nettype none
module tb;
	import tsl_pkg::*;
	// ****************************************************************
	// Clock, reset and design hookup
	// ****************************************************************
	logic          i_mclk;       // Sequencer clock
	logic          i_arst_n;     // Reset, active low
	tsl_req_t      req;          // Bus request
	logic [31:0]   rdata;        // Read data
	logic          wait_req;     // Bus stall
	logic          step_start;   // Step start pulse
	logic          step_done;    // Step done pulse
	tsl_limits_t   lim;          // Limit outputs
	logic          ce;           // Clock enable
	logic          rdv;          // Read data valid
	logic          rdv_seen;     // Read valid at the accepting edge
	logic          en_flag;      // Enable flag out
	logic          run_flag;     // Run flag out
	int            n_errors;     // Mismatch count
	int            cmp_count;    // Comparison count
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	tsl_limit_regs tsl_limit_regs_inst (
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(ce), .i_req(req),
		.o_readdata(rdata), .o_readdatavalid(rdv), .o_waitrequest(wait_req),
		.i_step_start(step_start), .o_step_done(step_done), .o_limits(lim),
		.o_enable(en_flag), .o_running(run_flag)
	);
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One bus access; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int k;
		@(posedge i_mclk);
		req <= '{address: a, read: ~wr, write: wr, writedata: d, byteenable: be};
		for (k = 0; k < 50; k++) begin
			@(posedge i_mclk);
			if (wait_req === 1'b0) break;
		end
		q = rdata;
		rdv_seen = rdv;
		if (k == 50) begin
			n_errors++;
			wrap_up();
		end
		req <= '0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask
	// Read one register and compare it
	task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, 4'hF, q);
		chk(what, q, exp);
		chk("read valid", {16'h0000, 15'h0000, rdv_seen}, 32'h0000_0001);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Cleared limits after reset
	task automatic t_reset;
		rd_chk("step_delay reset", OFF_STEP_DELAY, 32'h0000_0000);
		rd_chk("counter0 reset", OFF_CNT0_LIMIT, 32'h0000_0000);
		rd_chk("counter1 reset", OFF_CNT1_LIMIT, 32'h0000_0000);
		$display("test reset done");
	endtask
	// Writes land while unlocked, partial byte write keeps the high byte
	task automatic t_write;
		wr(OFF_STEP_DELAY, 32'hFFFF_1234, 4'hF);
		wr(OFF_CNT0_LIMIT, 32'h0000_ABCD, 4'h3);
		wr(OFF_CNT1_LIMIT, 32'h0000_5A5A, 4'h3);
		wr(OFF_CNT1_LIMIT, 32'h0000_00FF, 4'h1);
		rd_chk("step_delay rd", OFF_STEP_DELAY, 32'h0000_1234);
		rd_chk("counter0 rd", OFF_CNT0_LIMIT, 32'h0000_ABCD);
		rd_chk("counter1 rd", OFF_CNT1_LIMIT, 32'h0000_5AFF);
		chk("counter0 out", {16'h0000, lim.counter0}, 32'h0000_ABCD);
		chk("counter1 out", {16'h0000, lim.counter1}, 32'h0000_5AFF);
		$display("test write done");
	endtask
	// Step length is delay plus one clocks, plus f clocks frozen by the enable
	task automatic t_step(input logic [15:0] d, input int f);
		int n;
		wr(OFF_CONTROL, 32'h0000_0000, 4'h1);
		wr(OFF_STEP_DELAY, {16'h0000, d}, 4'h3);
		wr(OFF_CONTROL, 32'h0000_0003, 4'h1);
		chk("enable flag", {16'h0000, 15'h0000, en_flag}, 32'h0000_0001);
		chk("run flag", {16'h0000, 15'h0000, run_flag}, 32'h0000_0001);
		@(posedge i_mclk);
		step_start <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_mclk);
			step_start <= 1'b0;
			ce <= (n >= f);
			#1;
			if (step_done === 1'b1) break;
		end
		if (n == 40) begin
			n_errors++;
			wrap_up();
		end
		chk("step clocks", n, {16'h0000, d} + 32'(f) + 32'h0000_0001);
		$display("test step done");
	endtask
	// Locked writes to delay and counter 0 are dropped, counter 1 is not
	task automatic t_lock;
		wr(OFF_STEP_DELAY, 32'h0000_0077, 4'h3);
		wr(OFF_CNT0_LIMIT, 32'h0000_1111, 4'h3);
		wr(OFF_CNT1_LIMIT, 32'h0000_2222, 4'h3);
		rd_chk("delay locked", OFF_STEP_DELAY, 32'h0000_0000);
		rd_chk("counter0 locked", OFF_CNT0_LIMIT, 32'h0000_ABCD);
		rd_chk("counter1 open", OFF_CNT1_LIMIT, 32'h0000_2222);
		wr(OFF_CONTROL, 32'h0000_0001, 4'h1);
		chk("run flag cleared", {16'h0000, 15'h0000, run_flag}, 32'h0000_0000);
		wr(OFF_CNT0_LIMIT, 32'h0000_1111, 4'h3);
		rd_chk("counter0 unlocked", OFF_CNT0_LIMIT, 32'h0000_1111);
		$display("test lock done");
	endtask
	// Reset in mid-run clears limits that hold nonzero values
	task automatic t_rst_mid;
		@(posedge i_mclk);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		chk("delay after reset", {16'h0000, lim.step_delay}, 32'h0000_0000);
		chk("counter0 after reset", {16'h0000, lim.counter0}, 32'h0000_0000);
		chk("counter1 after reset", {16'h0000, lim.counter1}, 32'h0000_0000);
		rd_chk("counter0 reset read", OFF_CNT0_LIMIT, 32'h0000_0000);
		$display("test mid reset done");
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		n_errors = 0;
		cmp_count = 0;
		req = '0;
		step_start = 1'b0;
		ce = 1'b1;
		i_arst_n = 1'b0;
		repeat (2) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		t_reset();
		t_write();
		t_step(16'h0003, 0);
		t_step(16'h0001, 0);
		t_step(16'h0003, 3);
		t_step(16'h0000, 0);
		t_lock();
		t_rst_mid();
		wrap_up();
	end
endmodule
`default_nettype wire
